//--- logic/flow_ctrl_consts.svh
// Offsets, field positions, reset values and codes of the mode/mask front end
`ifndef FLOW_CTRL_CONSTS_SVH
`define FLOW_CTRL_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_WRITE_MASK    8'h00
`define OFS_ACCUM_VOLUME  8'h04
`define OFS_FLOW_TARGET   8'h08
`define OFS_VALVE_DRIVE   8'h0C
`define OFS_CONTROL_MODE  8'h10
`define OFS_FAULT_CLEAR   8'h14
`define OFS_PRESS_TARGET  8'h18
`define OFS_SOFT_RESET    8'h1C
`define OFS_FAULT_FLAGS   8'h20
`define OFS_IRQ_STATUS    8'h24
`define OFS_IRQ_MASK      8'h28
`define OFS_SETPOINT      8'h2C
`define OFS_FAULT_MUTED   8'h30

// ----------------------------------------
// Write mask bit positions
// ----------------------------------------
`define MB_ACCUM          0
`define MB_FLOW           1
`define MB_VALVE          2
`define MB_MODE           3
`define MB_FAULT_CLEAR    7
`define MB_PRESS          10
`define MB_SOFT_RESET     12
`define MASK_W            13

// ----------------------------------------
// Output register slots
// ----------------------------------------
`define SL_ACCUM          0
`define SL_FLOW           1
`define SL_VALVE          2
`define SL_MODE           3
`define SL_FAULT_CLEAR    4
`define SL_PRESS          5
`define SL_SOFT_RESET     6
`define NSLOT             7

// ----------------------------------------
// Mode codes, interrupt bits, reset values
// ----------------------------------------
`define MODE_FLOW         32'h0000_0001
`define MODE_PRESSURE     32'h0000_0005
`define MODE_MANUAL       32'h0000_000A
`define IRQ_FAULT         0
`define IRQ_SETPOINT      1
`define IRQ_REFUSED       2
`define IRQ_W             3
`define RST_MASK          13'h0000
`define RST_SLOT          32'h0000_0000
`define RST_IRQ           3'h0

`endif

//--- logic/flow_ctrl_pkg.sv
// Types shared by the mode/mask front end
package flow_ctrl_pkg;
  typedef enum logic [1:0] {KIND_IDLE, KIND_FLOW, KIND_PRESSURE, KIND_MANUAL} ctrl_kind_e;
  typedef logic [31:0] word_t;
endpackage

//--- logic/gated_reg.sv
// Output register that takes a write only when enabled and only when the value changes
`timescale 1ns/1ns
`include "flow_ctrl_consts.svh"
module gated_reg
  import flow_ctrl_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         wr_i,
  input  wire logic         enable_i,
  input  wire logic [W-1:0] data_i,
  output logic      [W-1:0] value_o,
  output logic              taken_o,
  output logic              refused_o
);
  logic [W-1:0] next_value;
  logic         next_taken;

  if (W < 1 || W > 32) begin : g_chk
    $error("gated_reg width must be 1 to 32");
  end

  assign refused_o = wr_i && !enable_i;

  always_comb begin
    next_value = value_o;
    next_taken = 1'b0;
    // Same value means no action, so a zero command must be preceded by a nonzero one
    if (wr_i && enable_i && data_i != value_o) begin
      next_value = data_i;
      next_taken = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      value_o <= W'(`RST_SLOT);
      taken_o <= 1'b0;
    end else begin
      value_o <= next_value;
      taken_o <= next_taken;
    end
  end
endmodule

//--- logic/output_write_mask_mode_control.sv
// APB front end: write mask, change-gated output registers, mode select, fault flags
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ns
`include "flow_ctrl_consts.svh"
module output_write_mask_mode_control
  import flow_ctrl_pkg::*;
#(
  parameter int FAULT_W = 16
) (
  input  wire logic               clk_i,
  input  wire logic               resetn_i,
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [7:0]         paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic      [31:0]        prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  input  wire logic [FAULT_W-1:0] fault_i,
  output logic      [FAULT_W-1:0] fault_flags_o,
  output logic      [15:0]        control_mode_o,
  output logic      [31:0]        setpoint_o,
  output ctrl_kind_e              setpoint_kind_o,
  output logic                    setpoint_load_o,
  output logic      [31:0]        accum_value_o,
  output logic                    accum_load_o,
  output logic                    soft_reset_o,
  output logic                    irq_o
);
  if (FAULT_W < 1 || FAULT_W > 32) begin : g_chk
    $error("FAULT_W must be 1 to 32");
  end

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic [7:0] slot_ofs(input int k);
    unique case (k)
      `SL_ACCUM:       slot_ofs = `OFS_ACCUM_VOLUME;
      `SL_FLOW:        slot_ofs = `OFS_FLOW_TARGET;
      `SL_VALVE:       slot_ofs = `OFS_VALVE_DRIVE;
      `SL_MODE:        slot_ofs = `OFS_CONTROL_MODE;
      `SL_FAULT_CLEAR: slot_ofs = `OFS_FAULT_CLEAR;
      `SL_PRESS:       slot_ofs = `OFS_PRESS_TARGET;
      default:         slot_ofs = `OFS_SOFT_RESET;
    endcase
  endfunction

  function automatic int slot_bit(input int k);
    unique case (k)
      `SL_ACCUM:       slot_bit = `MB_ACCUM;
      `SL_FLOW:        slot_bit = `MB_FLOW;
      `SL_VALVE:       slot_bit = `MB_VALVE;
      `SL_MODE:        slot_bit = `MB_MODE;
      `SL_FAULT_CLEAR: slot_bit = `MB_FAULT_CLEAR;
      `SL_PRESS:       slot_bit = `MB_PRESS;
      default:         slot_bit = `MB_SOFT_RESET;
    endcase
  endfunction

  function automatic ctrl_kind_e kind_of(input word_t code);
    if (code == `MODE_FLOW) begin
      kind_of = KIND_FLOW;
    end else if (code == `MODE_PRESSURE) begin
      kind_of = KIND_PRESSURE;
    end else if (code == `MODE_MANUAL) begin
      kind_of = KIND_MANUAL;
    end else begin
      kind_of = KIND_IDLE;
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [`MASK_W-1:0]  wmask;
  logic [`MASK_W-1:0]  next_wmask;
  logic [FAULT_W-1:0]  flags;
  logic [FAULT_W-1:0]  next_flags;
  logic [FAULT_W-1:0]  muted;
  logic [FAULT_W-1:0]  next_muted;
  logic [FAULT_W-1:0]  ack;
  logic [`IRQ_W-1:0]   irq_status;
  logic [`IRQ_W-1:0]   next_irq_status;
  logic [`IRQ_W-1:0]   irq_mask;
  logic [`IRQ_W-1:0]   next_irq_mask;
  logic [`IRQ_W-1:0]   ev;
  word_t               setpoint;
  word_t               next_setpoint;
  ctrl_kind_e          sp_kind;
  ctrl_kind_e          next_sp_kind;
  logic                sp_load;
  logic                next_sp_load;
  word_t               prdata;
  word_t               next_prdata;
  word_t               slot_val [`NSLOT];
  logic [`NSLOT-1:0]   slot_wr;
  logic [`NSLOT-1:0]   slot_en;
  logic [`NSLOT-1:0]   slot_taken;
  logic [`NSLOT-1:0]   slot_refused;
  logic                wr_go;
  logic                rd_setup;
  logic                mapped;
  ctrl_kind_e          mk;

  // One clock domain, so every check in this module shares it, the slot loop included
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  // ----------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------
  assign wr_go    = psel_i && penable_i && pwrite_i;
  assign rd_setup = psel_i && !penable_i && !pwrite_i;
  assign mapped   = (paddr_i <= `OFS_FAULT_MUTED) && (paddr_i[1:0] == 2'b00);
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  // ----------------------------------------
  // Gated output registers
  // ----------------------------------------
  for (genvar k = 0; k < `NSLOT; k++) begin : g_slot
    assign slot_wr[k] = wr_go && (paddr_i == slot_ofs(k));
    assign slot_en[k] = wmask[slot_bit(k)];

    gated_reg #(
      .W (32)
    ) u_reg (
      .clk_i     (clk_i),
      .resetn_i  (resetn_i),
      .wr_i      (slot_wr[k]),
      .enable_i  (slot_en[k]),
      .data_i    (pwdata_i),
      .value_o   (slot_val[k]),
      .taken_o   (slot_taken[k]),
      .refused_o (slot_refused[k])
    );

    masked_ignore_a: assert property (
      slot_wr[k] && !slot_en[k] |=> $stable(slot_val[k]) && !slot_taken[k])
      else $error("masked write changed an output register");
    same_value_a: assert property (
      slot_wr[k] && pwdata_i == slot_val[k] |=> !slot_taken[k] ##1 !slot_taken[k])
      else $error("write of unchanged value caused an action");
  end

  assign mk = kind_of(slot_val[`SL_MODE]);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_wmask      = wmask;
    next_irq_mask   = irq_mask;
    next_setpoint   = setpoint;
    next_sp_kind    = sp_kind;
    next_sp_load    = 1'b0;
    next_prdata     = prdata;
    ack             = '0;
    // Mask register has no gate of its own
    if (wr_go && paddr_i == `OFS_WRITE_MASK) begin
      next_wmask = pwdata_i[`MASK_W-1:0];
    end
    if (wr_go && paddr_i == `OFS_IRQ_MASK) begin
      next_irq_mask = pwdata_i[`IRQ_W-1:0];
    end

    // Only acknowledge bits that are actually raised, so a stray write mutes nothing
    if (slot_taken[`SL_FAULT_CLEAR]) begin
      ack = slot_val[`SL_FAULT_CLEAR][FAULT_W-1:0] & flags;
    end
    // Set wins over clear; muted faults never set again
    next_flags = (flags & ~ack) | (fault_i & ~muted);
    if (slot_taken[`SL_SOFT_RESET]) begin
      next_muted = '0;
    end else begin
      next_muted = muted | ack;
    end

    // Taken pulses never coincide: APB writes are at least two cycles apart
    if (slot_taken[`SL_MODE]) begin
      next_sp_kind = mk;
      unique case (mk)
        KIND_FLOW: begin
          if (wmask[`MB_FLOW]) begin
            next_setpoint = slot_val[`SL_FLOW];
            next_sp_load  = 1'b1;
          end
        end
        KIND_PRESSURE: begin
          if (wmask[`MB_PRESS]) begin
            next_setpoint = slot_val[`SL_PRESS];
            next_sp_load  = 1'b1;
          end
        end
        KIND_MANUAL: begin
          if (wmask[`MB_VALVE]) begin
            next_setpoint = slot_val[`SL_VALVE];
            next_sp_load  = 1'b1;
          end
        end
        KIND_IDLE: begin
          next_sp_load = 1'b0;
        end
      endcase
    end else if (slot_taken[`SL_FLOW] && mk == KIND_FLOW) begin
      next_setpoint = slot_val[`SL_FLOW];
      next_sp_load  = 1'b1;
    end else if (slot_taken[`SL_PRESS] && mk == KIND_PRESSURE) begin
      next_setpoint = slot_val[`SL_PRESS];
      next_sp_load  = 1'b1;
    end else if (slot_taken[`SL_VALVE] && mk == KIND_MANUAL) begin
      next_setpoint = slot_val[`SL_VALVE];
      next_sp_load  = 1'b1;
    end

    ev[`IRQ_FAULT]    = |(fault_i & ~muted & ~flags);
    ev[`IRQ_SETPOINT] = next_sp_load;
    ev[`IRQ_REFUSED]  = |slot_refused;
    next_irq_status = irq_status;
    if (wr_go && paddr_i == `OFS_IRQ_STATUS) begin
      next_irq_status = irq_status & ~pwdata_i[`IRQ_W-1:0];
    end
    next_irq_status = next_irq_status | ev;

    // Read data is latched in the setup phase so it comes from a flop in the access phase
    if (rd_setup) begin
      unique case (paddr_i)
        `OFS_WRITE_MASK:   next_prdata = 32'(wmask);
        `OFS_ACCUM_VOLUME: next_prdata = slot_val[`SL_ACCUM];
        `OFS_FLOW_TARGET:  next_prdata = slot_val[`SL_FLOW];
        `OFS_VALVE_DRIVE:  next_prdata = slot_val[`SL_VALVE];
        `OFS_CONTROL_MODE: next_prdata = slot_val[`SL_MODE];
        `OFS_FAULT_CLEAR:  next_prdata = slot_val[`SL_FAULT_CLEAR];
        `OFS_PRESS_TARGET: next_prdata = slot_val[`SL_PRESS];
        `OFS_SOFT_RESET:   next_prdata = slot_val[`SL_SOFT_RESET];
        `OFS_FAULT_FLAGS:  next_prdata = 32'(flags);
        `OFS_IRQ_STATUS:   next_prdata = 32'(irq_status);
        `OFS_IRQ_MASK:     next_prdata = 32'(irq_mask);
        `OFS_SETPOINT:     next_prdata = setpoint;
        `OFS_FAULT_MUTED:  next_prdata = 32'(muted);
        default:           next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wmask      <= `RST_MASK;
      flags      <= '0;
      muted      <= '0;
      irq_status <= `RST_IRQ;
      irq_mask   <= `RST_IRQ;
      setpoint   <= `RST_SLOT;
      sp_kind    <= KIND_IDLE;
      sp_load    <= 1'b0;
      prdata     <= 32'h0000_0000;
    end else begin
      wmask      <= next_wmask;
      flags      <= next_flags;
      muted      <= next_muted;
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
      setpoint   <= next_setpoint;
      sp_kind    <= next_sp_kind;
      sp_load    <= next_sp_load;
      prdata     <= next_prdata;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata_o        = prdata;
  assign fault_flags_o   = flags;
  assign control_mode_o  = slot_val[`SL_MODE][15:0];
  assign setpoint_o      = setpoint;
  assign setpoint_kind_o = sp_kind;
  assign setpoint_load_o = sp_load;
  assign accum_value_o   = slot_val[`SL_ACCUM];
  assign accum_load_o    = slot_taken[`SL_ACCUM];
  assign soft_reset_o    = slot_taken[`SL_SOFT_RESET];
  assign irq_o           = |(irq_status & irq_mask);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  mask_map_a: assert property (
    slot_en == {wmask[12], wmask[10], wmask[7], wmask[3], wmask[2], wmask[1], wmask[0]})
    else $error("mask bit to register mapping broken");
  mask_always_a: assert property (
    wr_go && paddr_i == `OFS_WRITE_MASK |=> wmask == $past(pwdata_i[`MASK_W-1:0]))
    else $error("write mask not taken");
  press_effect_a: assert property (
    slot_taken[`SL_PRESS] && mk != KIND_PRESSURE |=> !setpoint_load_o)
    else $error("pressure target acted outside pressure mode");
  manual_drive_a: assert property (
    slot_taken[`SL_VALVE] && mk == KIND_MANUAL
    |=> setpoint_load_o && setpoint_o == $past(slot_val[`SL_VALVE]) && setpoint_kind_o == KIND_MANUAL)
    else $error("valve drive not applied in manual mode");
  flow_only_a: assert property (
    setpoint_load_o && setpoint_kind_o == KIND_FLOW
    |-> setpoint_o == slot_val[`SL_FLOW] && control_mode_o == 16'h0001)
    else $error("flow target applied outside flow mode");
  mode_adopt_a: assert property (
    slot_taken[`SL_MODE] && mk == KIND_PRESSURE && wmask[`MB_PRESS]
    |=> setpoint_load_o && setpoint_o == $past(slot_val[`SL_PRESS]))
    else $error("pressure target not adopted on mode switch");
  // A fault arriving with its own clear sets the flag again, so those bits are excused
  fault_ack_a: assert property (
    slot_taken[`SL_FAULT_CLEAR]
    |=> (fault_flags_o & $past(slot_val[`SL_FAULT_CLEAR][FAULT_W-1:0] & flags & ~fault_i)) == '0)
    else $error("acknowledged fault flags not cleared");
  ack_mute_a: assert property (
    slot_taken[`SL_FAULT_CLEAR] |=> (muted & $past(ack)) == $past(ack))
    else $error("acknowledged fault not muted");
  soft_rearm_a: assert property (
    slot_taken[`SL_SOFT_RESET] |=> muted == '0)
    else $error("soft reset did not re-arm muted faults");
  fault_set_a: assert property (
    |(fault_i & ~muted) |=> (fault_flags_o & $past(fault_i & ~muted)) == $past(fault_i & ~muted))
    else $error("fault cause did not raise its flag");
  refused_flag_a: assert property (
    |slot_refused |=> irq_status[`IRQ_REFUSED])
    else $error("refused write not flagged");
  mode_kind_a: assert property (
    slot_taken[`SL_MODE] |=> setpoint_kind_o == $past(mk))
    else $error("setpoint kind did not follow the mode");
  held_target_a: assert property (
    slot_taken[`SL_MODE] && mk == KIND_PRESSURE && !wmask[`MB_PRESS] |=> !setpoint_load_o && $stable(setpoint_o))
    else $error("disabled target adopted on mode switch");
  muted_fault_a: assert property (
    ((flags & ~$past(flags)) & $past(muted)) == '0)
    else $error("acknowledged fault reported again");
  sticky_flag_a: assert property (
    |($past(flags) & ~flags) |-> $past(slot_taken[`SL_FAULT_CLEAR]))
    else $error("fault flag fell without a clear write");

  switch_adopt_c: cover property (slot_taken[`SL_MODE] ##1 setpoint_load_o);
  fault_ack_c: cover property (|flags ##[1:50] slot_taken[`SL_FAULT_CLEAR]);
  refused_write_c: cover property (|slot_refused);
  soft_rearm_c: cover property (|muted ##[1:50] soft_reset_o);
  manual_drive_c: cover property (slot_taken[`SL_VALVE] && mk == KIND_MANUAL);
endmodule

//--- tb/plc_master.sv
// APB master model standing in for the fieldbus controller
`timescale 1ns/1ns
module plc_master (
  input  wire logic        clk_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [7:0]       paddr_o,
  output logic [31:0]      pwdata_o,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i
);
  logic [31:0] rdata;
  logic        rerr;

  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 8'hFF;
    pwdata_o  = 32'hFFFF_FFFF;
    rdata     = 32'h0;
    rerr      = 1'b0;
  end

  // ----------------------------------------
  // One transfer
  // ----------------------------------------
  // Starts on a fresh edge so two calls never drive psel in one time step.
  // Released address and data show the inverse, so nothing relies on stale values.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_o    <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o  <= wr;
    paddr_o   <= a;
    pwdata_o  <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    rdata = prdata_i;
    rerr  = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    paddr_o   <= ~a;
    pwdata_o  <= ~d;
  endtask
endmodule

//--- tb/tb.sv
// Self-checking bench for the mask, mode and fault front end
`timescale 1ns/1ns
`include "flow_ctrl_consts.svh"
module tb;
  import flow_ctrl_pkg::*;
  localparam int FW = 16;
  logic          clk_i;
  logic          resetn_i;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [7:0]    paddr;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic [FW-1:0] fault;
  logic [FW-1:0] flags;
  logic [15:0]   mode;
  logic [31:0]   setpoint;
  ctrl_kind_e    kind;
  logic          sp_load;
  logic [31:0]   accum;
  logic          acc_load;
  logic          srst;
  logic          irq;
  int            n_mismatch;
  int            checks_done;
  int            n_acc;
  int            n_srst;
  int            n_ld;

  output_write_mask_mode_control #(.FAULT_W(FW)) u_output_write_mask_mode_control (
    .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .fault_i(fault), .fault_flags_o(flags),
    .control_mode_o(mode), .setpoint_o(setpoint), .setpoint_kind_o(kind),
    .setpoint_load_o(sp_load), .accum_value_o(accum), .accum_load_o(acc_load),
    .soft_reset_o(srst), .irq_o(irq)
  );

  plc_master plc (
    .clk_i(clk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr)
  );

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Pulses are counted rather than caught, so checks need not hit the exact cycle
  always @(posedge clk_i) begin
    if (acc_load === 1'b1) n_acc++;
    if (srst === 1'b1) n_srst++;
    if (sp_load === 1'b1) n_ld++;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Two extra edges let the setpoint load one cycle after the commit land
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    plc.xfer(1'b1, a, d);
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    plc.xfer(1'b0, a, 32'h0);
    check(what, plc.rdata, exp);
  endtask

  task automatic pulse_fault(input logic [FW-1:0] f);
    @(posedge clk_i);
    fault <= f;
    @(posedge clk_i);
    fault <= '0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic tally_and_finish;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    tally_and_finish;
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    resetn_i    = 1'b0;
    fault       = '0;
    n_mismatch  = 0;
    checks_done = 0;
    n_acc       = 0;
    n_srst      = 0;
    n_ld        = 0;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(`OFS_WRITE_MASK, 32'h0, "mask");
    check("kind", {30'h0, kind}, {30'h0, KIND_IDLE});
    // A write with its mask bit clear is dropped and flags the refused interrupt
    wr(`OFS_IRQ_MASK, 32'h0000_0004);
    wr(`OFS_ACCUM_VOLUME, 32'h0000_0005);
    rd(`OFS_ACCUM_VOLUME, 32'h0, "accum");
    check("irq set", {31'h0, irq}, 32'h1);
    wr(`OFS_IRQ_STATUS, 32'h0000_0007);
    check("irq clear", {31'h0, irq}, 32'h0);
    wr(`OFS_WRITE_MASK, 32'h0000_0003);
    wr(`OFS_ACCUM_VOLUME, 32'h0000_0005);
    check("accum", accum, 32'h0000_0005);
    wr(`OFS_FLOW_TARGET, 32'h0000_0007);
    rd(`OFS_FLOW_TARGET, 32'h0000_0007, "flow");
    wr(`OFS_VALVE_DRIVE, 32'h0000_0019);
    rd(`OFS_VALVE_DRIVE, 32'h0, "valve");
    // Repeating a zero needs a nonzero write in between
    wr(`OFS_ACCUM_VOLUME, 32'h0);
    wr(`OFS_ACCUM_VOLUME, 32'h0);
    check("accum pulses", n_acc, 32'h2);
    wr(`OFS_ACCUM_VOLUME, 32'h0000_0001);
    wr(`OFS_ACCUM_VOLUME, 32'h0);
    check("accum pulses", n_acc, 32'h4);
    // Manual valve mode
    wr(`OFS_WRITE_MASK, 32'h0000_000C);
    wr(`OFS_CONTROL_MODE, 32'h0000_000A);
    check("mode", {16'h0, mode}, 32'h0000_000A);
    check("kind", {30'h0, kind}, {30'h0, KIND_MANUAL});
    wr(`OFS_VALVE_DRIVE, 32'h0000_0019);
    check("valve sp", setpoint, 32'h0000_0019);
    // Stored targets are adopted on a mode switch only while their mask bit is set
    wr(`OFS_WRITE_MASK, 32'h0000_040E);
    wr(`OFS_PRESS_TARGET, 32'h0000_0002);
    check("press early", setpoint, 32'h0000_0019);
    check("loads", n_ld, 32'h2);
    wr(`OFS_CONTROL_MODE, 32'h0000_0005);
    check("kind", {30'h0, kind}, {30'h0, KIND_PRESSURE});
    check("press sp", setpoint, 32'h0000_0002);
    wr(`OFS_CONTROL_MODE, 32'h0000_0001);
    check("kind", {30'h0, kind}, {30'h0, KIND_FLOW});
    check("flow sp", setpoint, 32'h0000_0007);
    wr(`OFS_PRESS_TARGET, 32'h0000_0003);
    check("press in flow", setpoint, 32'h0000_0007);
    wr(`OFS_WRITE_MASK, 32'h0000_0008);
    rd(`OFS_WRITE_MASK, 32'h0000_0008, "mask");
    wr(`OFS_CONTROL_MODE, 32'h0000_0005);
    check("held sp", setpoint, 32'h0000_0007);
    check("loads", n_ld, 32'h4);
    // Fault flags: sticky, acknowledged, muted, re-armed by soft reset
    pulse_fault(16'h0008);
    check("flags", {16'h0, flags}, 32'h0000_0008);
    wr(`OFS_FAULT_CLEAR, 32'h0000_0008);
    check("flags", {16'h0, flags}, 32'h0000_0008);
    wr(`OFS_WRITE_MASK, 32'h0000_1080);
    rd(`OFS_FAULT_FLAGS, 32'h0000_0008, "flags rd");
    wr(`OFS_FAULT_CLEAR, plc.rdata);
    check("flags", {16'h0, flags}, 32'h0);
    pulse_fault(16'h0008);
    check("muted", {16'h0, flags}, 32'h0);
    wr(`OFS_SOFT_RESET, 32'h0000_0001);
    check("soft pulses", n_srst, 32'h1);
    pulse_fault(16'h0008);
    check("rearmed", {16'h0, flags}, 32'h0000_0008);
    wr(`OFS_FAULT_CLEAR, 32'h0000_0008);
    check("same ack", {16'h0, flags}, 32'h0000_0008);
    wr(`OFS_FAULT_CLEAR, 32'h0);
    wr(`OFS_FAULT_CLEAR, 32'h0000_0008);
    check("reack", {16'h0, flags}, 32'h0);
    // Unmapped address answers with an error
    plc.xfer(1'b0, 8'h34, 32'h0);
    check("slverr", {31'h0, plc.rerr}, 32'h1);
    tally_and_finish;
  end
endmodule
